//--- rtl/timer16_pkg.sv
// Package for the 16-bit capture/compare timer.
// Assumes one 20 MHz clock and a classic Wishbone slave with 32-bit data.
package timer16_pkg;

    // Register byte offsets
    localparam logic [4:0] OFS_MODE = 5'h00;
    localparam logic [4:0] OFS_CAPCOMP = 5'h04;
    localparam logic [4:0] OFS_OUTCTL = 5'h08;
    localparam logic [4:0] OFS_PRESC = 5'h0C;
    localparam logic [4:0] OFS_COUNT = 5'h10;
    localparam logic [4:0] OFS_CC_A = 5'h14;
    localparam logic [4:0] OFS_CC_B = 5'h18;

    // Mode control fields
    localparam int MODE_OVF_BIT = 0;
    localparam int MODE_TOGGLE_BIT = 1;
    localparam int MODE_OP_LO = 2;
    localparam logic [1:0] OP_STOP = 2'h0;
    localparam logic [1:0] OP_FREE_RUN = 2'h1;
    localparam logic [1:0] OP_CLEAR_START = 2'h2;

    // Capture/compare control fields
    localparam int CC_A_CAPTURE_BIT = 0;
    localparam int CC_REVERSE_BIT = 1;
    localparam int CC_B_CAPTURE_BIT = 2;

    // Output control fields
    localparam int OUT_ENABLE_BIT = 0;

    // Prescaler fields
    localparam int PRESC_SEL_LO = 0;
    localparam int PRESC_ES_PRI_LO = 4;
    localparam int PRESC_ES_SEC_LO = 6;
    localparam logic [1:0] ES_FALLING = 2'h0;
    localparam logic [1:0] ES_RISING = 2'h1;
    localparam logic [1:0] ES_NONE = 2'h2;
    localparam logic [1:0] ES_BOTH = 2'h3;

    // Count clock dividers, cycles of sys_clk minus one
    localparam logic [4:0] DIV_SEL0 = 5'h01;
    localparam logic [4:0] DIV_SEL1 = 5'h07;
    localparam logic [4:0] DIV_SEL2 = 5'h1F;
    localparam logic [1:0] SEL_TRIGGER = 2'h3;

    // Reset values and counter full scale
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] CC_RESET = 16'h0000;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [15:0] COUNT_FULL = 16'hFFFF;

    // Edge pair seen on one trigger input
    typedef struct packed {
        logic rise;
        logic fall;
    } edge_s;

endpackage : timer16_pkg

//--- rtl/timer16_capture_freerun.sv
// 16-bit up counter with two capture/compare registers, free-running and
// clear-and-start modes, a toggling output pin and a Wishbone register port.
// Assumes trigger inputs already synchronous to sys_clk.
//
// Contract
// - Mode 10 selects clear-and-start on primary edge
// - Trigger edge needs two consecutive equal samples
// - Primary valid edge clears counter in clear-and-start
// - Reverse phase captures A without interrupt A
// - Secondary edge then raises interrupt A only
// - Toggle output on trigger clear and B match
// - Both capture: primary edge captures B, clears
// - Secondary edge captures into A, raises interrupt
// - Edge select 11 detects both edges
// - Register A source primary or secondary trigger
// - Register B always captures on primary edge
// - Output pin unavailable while secondary detection used
// - Compare match raises interrupt, counter not cleared
// - Mode 01 selects free-running upward count
// - Full scale wraps to zero, sets overflow
// - Free-run supports all compare/capture mixes
// - Free-run compare matches toggle and interrupt
// - Free-run B capture on primary edge, interrupt
// - Free-run both capture toggles only if enabled
module timer16_capture_freerun (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Trigger inputs
    input wire logic trigger_input_primary,
    input wire logic trigger_input_secondary,
    // Timer output and event pulses
    output logic timer_output_pin,
    output logic interrupt_a,
    output logic interrupt_b
);

    logic [7:0] mode_control_reg_ff;
    logic [7:0] capcomp_control_reg_ff;
    logic [7:0] output_control_reg_ff;
    logic [7:0] prescaler_mode_reg_ff;
    logic [15:0] timer_count_ff;
    logic [15:0] capture_compare_a_ff;
    logic [15:0] capture_compare_b_ff;
    logic overflow_flag_ff;
    logic [1:0] pri_samp_ff;
    logic [1:0] sec_samp_ff;
    logic pri_level_ff;
    logic sec_level_ff;
    logic [4:0] div_ff;
    logic count_new_ff;
    logic out_level_ff;
    logic ack_ff;

    logic wr_hit;
    logic [1:0] op_mode;
    logic toggle_on_trigger;
    logic a_capture;
    logic b_capture;
    logic reverse_phase_select;
    logic [1:0] es_pri;
    logic [1:0] es_sec;
    logic [1:0] clk_sel;
    logic [4:0] div_max;
    logic running;
    logic tick;
    timer16_pkg::edge_s pri_edge;
    timer16_pkg::edge_s sec_edge;
    logic pri_valid;
    logic pri_reverse;
    logic sec_valid;
    logic clear_evt;
    logic match_a;
    logic match_b;
    logic cap_a;
    logic cap_b;
    logic irq_a;
    logic irq_b;
    logic toggle;
    logic pin_free;
    logic wr_mode;

    // Field decode
    assign op_mode = mode_control_reg_ff[timer16_pkg::MODE_OP_LO +: 2];
    assign toggle_on_trigger = mode_control_reg_ff[timer16_pkg::MODE_TOGGLE_BIT];
    assign a_capture = capcomp_control_reg_ff[timer16_pkg::CC_A_CAPTURE_BIT];
    assign b_capture = capcomp_control_reg_ff[timer16_pkg::CC_B_CAPTURE_BIT];
    assign reverse_phase_select = capcomp_control_reg_ff[timer16_pkg::CC_REVERSE_BIT];
    assign es_pri = prescaler_mode_reg_ff[timer16_pkg::PRESC_ES_PRI_LO +: 2];
    assign es_sec = prescaler_mode_reg_ff[timer16_pkg::PRESC_ES_SEC_LO +: 2];
    assign clk_sel = prescaler_mode_reg_ff[timer16_pkg::PRESC_SEL_LO +: 2];
    assign running = (op_mode != timer16_pkg::OP_STOP);
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff && wb_sel_i[0];
    assign wr_mode = wr_hit && (wb_adr_i == timer16_pkg::OFS_MODE);

    // Trigger sampling, a change counts only after two equal samples
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pri_samp_ff <= 2'h0;
            sec_samp_ff <= 2'h0;
            pri_level_ff <= 1'b0;
            sec_level_ff <= 1'b0;
        end else begin
            pri_samp_ff <= {pri_samp_ff[0], trigger_input_primary};
            sec_samp_ff <= {sec_samp_ff[0], trigger_input_secondary};
            if (pri_samp_ff[0] == pri_samp_ff[1]) begin
                pri_level_ff <= pri_samp_ff[1];
            end
            if (sec_samp_ff[0] == sec_samp_ff[1]) begin
                sec_level_ff <= sec_samp_ff[1];
            end
        end
    end

    // Filtered edges and the selected valid edges
    always_comb begin
        pri_edge.rise = (pri_samp_ff == 2'h3) && !pri_level_ff;
        pri_edge.fall = (pri_samp_ff == 2'h0) && pri_level_ff;
        sec_edge.rise = (sec_samp_ff == 2'h3) && !sec_level_ff;
        sec_edge.fall = (sec_samp_ff == 2'h0) && sec_level_ff;
        case (es_pri)
            timer16_pkg::ES_FALLING: begin
                pri_valid = pri_edge.fall;
                pri_reverse = pri_edge.rise;
            end
            timer16_pkg::ES_RISING: begin
                pri_valid = pri_edge.rise;
                pri_reverse = pri_edge.fall;
            end
            timer16_pkg::ES_BOTH: begin
                pri_valid = pri_edge.rise || pri_edge.fall;
                pri_reverse = pri_edge.rise || pri_edge.fall;
            end
            default: begin
                pri_valid = 1'b0;
                pri_reverse = 1'b0;
            end
        endcase
        case (es_sec)
            timer16_pkg::ES_FALLING: sec_valid = sec_edge.fall;
            timer16_pkg::ES_RISING: sec_valid = sec_edge.rise;
            timer16_pkg::ES_BOTH: sec_valid = sec_edge.rise || sec_edge.fall;
            default: sec_valid = 1'b0;
        endcase
    end

    // Count clock select; trigger-driven counting kept for completeness
    always_comb begin
        case (clk_sel)
            2'h0: div_max = timer16_pkg::DIV_SEL0;
            2'h1: div_max = timer16_pkg::DIV_SEL1;
            default: div_max = timer16_pkg::DIV_SEL2;
        endcase
    end

    // Prescaler divider gives a one-cycle count enable
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 5'h00;
        end else if (!running || div_ff >= div_max) begin
            div_ff <= 5'h00;
        end else begin
            div_ff <= div_ff + 5'h01;
        end
    end

    assign tick = running && ((clk_sel == timer16_pkg::SEL_TRIGGER) ? pri_valid
                                                                     : (div_ff == div_max));
    assign clear_evt = (op_mode == timer16_pkg::OP_CLEAR_START) && pri_valid;

    // Up counter; a clear event takes priority over the tick
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_count_ff <= timer16_pkg::COUNT_RESET;
            count_new_ff <= 1'b0;
        end else begin
            count_new_ff <= 1'b0;
            if (!running) begin
                timer_count_ff <= timer16_pkg::COUNT_RESET;
            end else if (clear_evt) begin
                timer_count_ff <= timer16_pkg::COUNT_RESET;
                count_new_ff <= 1'b1;
            end else if (tick) begin
                timer_count_ff <= timer_count_ff + 16'h0001;
                count_new_ff <= 1'b1;
            end
        end
    end

    // Overflow: set wins over a clearing write in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag_ff <= 1'b0;
        end else if (tick && !clear_evt && timer_count_ff == timer16_pkg::COUNT_FULL) begin
            overflow_flag_ff <= 1'b1;
        end else if (wr_mode && !wb_dat_i[timer16_pkg::MODE_OVF_BIT]) begin
            overflow_flag_ff <= 1'b0;
        end
    end

    // Compare matches fire once per new counter value
    assign match_a = count_new_ff && !a_capture && (timer_count_ff == capture_compare_a_ff);
    assign match_b = count_new_ff && !b_capture && (timer_count_ff == capture_compare_b_ff);

    // Capture sources for A and B
    assign cap_a = running && a_capture &&
                   (reverse_phase_select ? pri_reverse : sec_valid);
    assign cap_b = running && b_capture && pri_valid;

    // Interrupt A: compare match or secondary edge, never on reverse phase
    assign irq_a = match_a || (running && a_capture && sec_valid);
    assign irq_b = match_b || cap_b;

    // Toggle on either match, or on primary edge when enabled
    assign toggle = match_a || match_b ||
                    (running && toggle_on_trigger && pri_valid);
    assign pin_free = !(a_capture && !reverse_phase_select);

    // Register writes and captures; a capture wins over a write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_compare_a_ff <= timer16_pkg::CC_RESET;
            capture_compare_b_ff <= timer16_pkg::CC_RESET;
        end else begin
            if (cap_a) begin
                capture_compare_a_ff <= timer_count_ff;
            end else if (wr_hit && wb_adr_i == timer16_pkg::OFS_CC_A) begin
                capture_compare_a_ff <= wb_dat_i[15:0];
            end
            if (cap_b) begin
                capture_compare_b_ff <= timer_count_ff;
            end else if (wr_hit && wb_adr_i == timer16_pkg::OFS_CC_B) begin
                capture_compare_b_ff <= wb_dat_i[15:0];
            end
        end
    end

    // Control registers, low byte only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_control_reg_ff <= timer16_pkg::CTL_RESET;
            capcomp_control_reg_ff <= timer16_pkg::CTL_RESET;
            output_control_reg_ff <= timer16_pkg::CTL_RESET;
            prescaler_mode_reg_ff <= timer16_pkg::CTL_RESET;
        end else if (wr_hit) begin
            case (wb_adr_i)
                timer16_pkg::OFS_MODE: mode_control_reg_ff <= wb_dat_i[7:0];
                timer16_pkg::OFS_CAPCOMP: capcomp_control_reg_ff <= wb_dat_i[7:0];
                timer16_pkg::OFS_OUTCTL: output_control_reg_ff <= wb_dat_i[7:0];
                timer16_pkg::OFS_PRESC: prescaler_mode_reg_ff <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Output level and registered pin; pin held low when not available
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_level_ff <= 1'b0;
            timer_output_pin <= 1'b0;
        end else begin
            if (!output_control_reg_ff[timer16_pkg::OUT_ENABLE_BIT]) begin
                out_level_ff <= 1'b0;
            end else if (toggle) begin
                out_level_ff <= !out_level_ff;
            end
            timer_output_pin <= out_level_ff && pin_free;
        end
    end

    // Event pulses, one cycle each
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_a <= 1'b0;
            interrupt_b <= 1'b0;
        end else begin
            interrupt_a <= irq_a;
            interrupt_b <= irq_b;
        end
    end

    // Wishbone answer one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
            wb_dat_o <= 32'h0000_0000;
            if (wb_cyc_i && wb_stb_i && !ack_ff && !wb_we_i) begin
                case (wb_adr_i)
                    timer16_pkg::OFS_MODE:
                        wb_dat_o <= {24'h00_0000, mode_control_reg_ff[7:1], overflow_flag_ff};
                    timer16_pkg::OFS_CAPCOMP: wb_dat_o <= {24'h00_0000, capcomp_control_reg_ff};
                    timer16_pkg::OFS_OUTCTL: wb_dat_o <= {24'h00_0000, output_control_reg_ff};
                    timer16_pkg::OFS_PRESC: wb_dat_o <= {24'h00_0000, prescaler_mode_reg_ff};
                    timer16_pkg::OFS_COUNT: wb_dat_o <= {16'h0000, timer_count_ff};
                    timer16_pkg::OFS_CC_A: wb_dat_o <= {16'h0000, capture_compare_a_ff};
                    timer16_pkg::OFS_CC_B: wb_dat_o <= {16'h0000, capture_compare_b_ff};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign wb_ack_o = ack_ff;

    // Checks
    mode_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (running && op_mode != timer16_pkg::OP_CLEAR_START && !tick)
            |=> timer_count_ff == $past(timer_count_ff))
        else $error("counter moved outside clear-and-start mode");
    filter_two_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pri_edge.rise |-> $past(trigger_input_primary, 1) && $past(trigger_input_primary, 2))
        else $error("edge accepted without two samples");
    clear_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (op_mode == timer16_pkg::OP_CLEAR_START && pri_valid)
            |=> timer_count_ff == timer16_pkg::COUNT_RESET)
        else $error("counter not cleared by trigger");
    rev_noirq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cap_a && reverse_phase_select && !sec_valid && !match_a) |=> !interrupt_a)
        else $error("reverse capture raised interrupt A");
    sec_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (running && a_capture && sec_valid) |=> interrupt_a)
        else $error("secondary edge gave no interrupt A");
    cap_b_val_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cap_b |=> capture_compare_b_ff == $past(timer_count_ff) && interrupt_b)
        else $error("register B capture wrong");
    cap_a_val_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cap_a |=> capture_compare_a_ff == $past(timer_count_ff))
        else $error("register A capture wrong");
    pin_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (a_capture && !reverse_phase_select) [*2] |-> !timer_output_pin)
        else $error("output pin driven while unavailable");
    match_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        match_b |=> interrupt_b && (timer_count_ff == $past(timer_count_ff) || $past(tick)
            || $past(clear_evt) || !$past(running)))
        else $error("compare match lost or cleared counter");
    wrap_ovf_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && !clear_evt && timer_count_ff == timer16_pkg::COUNT_FULL)
            |=> overflow_flag_ff && timer_count_ff == timer16_pkg::COUNT_RESET)
        else $error("wrap did not set overflow");
    toggle_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (toggle && output_control_reg_ff[timer16_pkg::OUT_ENABLE_BIT])
            |=> out_level_ff != $past(out_level_ff))
        else $error("output level did not toggle");
    count_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && !clear_evt) |=> timer_count_ff == $past(timer_count_ff) + 16'h0001)
        else $error("counter did not advance");

endmodule : timer16_capture_freerun

//--- testbench/trigger_source.sv
// Model of the two external trigger sources feeding the timer.
// Assumes the bench calls its tasks; levels change just after sys_clk rises.
module trigger_source (
    // Clock
    input wire logic sys_clk,
    // Trigger levels
    output logic pri,
    output logic sec
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet lines; called while reset is held, so no false edge follows it
    task automatic idle();
        pri <= 1'b0;
        sec <= 1'b0;
    endtask : idle

    // New level held six cycles: filter, capture, pulse and pin all settle
    task automatic set_pin(input bit which, input logic lvl);
        @(posedge sys_clk);
        if (which) begin
            sec <= lvl;
        end else begin
            pri <= lvl;
        end
        repeat (6) @(posedge sys_clk);
    endtask : set_pin

    // One-cycle spike on the primary line, meant to be filtered out
    task automatic glitch();
        @(posedge sys_clk);
        pri <= ~pri;
        @(posedge sys_clk);
        pri <= ~pri;
        repeat (4) @(posedge sys_clk);
    endtask : glitch
endmodule : trigger_source

//--- testbench/test_timer16_capture_freerun.sv
// Self-checking bench for the capture/compare timer.
// Assumes Wishbone answers one cycle after the request is taken.
module test_timer16_capture_freerun;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [4:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, va, vb;
    logic wb_ack_o, pri, sec, timer_output_pin, interrupt_a, interrupt_b;
    int n_fail = 0, num_checks = 0, cycles = 0, cnt_a = 0, cnt_b = 0, sa, sb;

    timer16_capture_freerun i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .trigger_input_primary(pri), .trigger_input_secondary(sec),
        .timer_output_pin(timer_output_pin), .interrupt_a(interrupt_a),
        .interrupt_b(interrupt_b));
    trigger_source i_src (.sys_clk(sys_clk), .pri(pri), .sec(sec));

    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Pulse counters; scenarios compare snapshots, never absolute totals
    always @(posedge sys_clk) begin
        cycles++;
        if (interrupt_a === 1'b1) cnt_a++;
        if (interrupt_b === 1'b1) cnt_b++;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic check_true(input string what, input logic cond);
        check(what, {31'h0000_0000, cond}, 32'h0000_0001);
    endtask : check_true

    // Classic cycle; waits for ack, only the watchdog ends a hang
    task automatic wb_cycle(input logic we, input logic [4:0] adr, input logic [31:0] d,
                            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1);
        check("bus ack cycles", n, 32'h0000_0002);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_cycle

    task automatic wr(input logic [4:0] adr, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, adr, d, q);
    endtask : wr

    task automatic rd(input logic [4:0] adr, output logic [31:0] q);
        wb_cycle(1'b0, adr, 32'h0000_0000, q);
    endtask : rd

    // Bounded wait for the next interrupt pulse, then let the pin settle
    task automatic wait_int(input bit on_b);
        int start, n;
        start = on_b ? cnt_b : cnt_a;
        n = 0;
        while ((on_b ? cnt_b : cnt_a) == start && n < 600) begin
            @(posedge sys_clk);
            n++;
        end
        check_true("interrupt seen", n < 600);
        repeat (2) @(posedge sys_clk);
    endtask : wait_int

    task automatic do_reset();
        rst_n <= 1'b0;
        i_src.idle();
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask : do_reset

    // Main sequence; each scenario starts from reset
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 5'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        do_reset();
        // Reset values, unmapped read, software clear of the overflow flag
        rd(timer16_pkg::OFS_COUNT, va);
        check("count reset", va, 32'h0000_0000);
        rd(5'h1C, va);
        check("unmapped read", va, 32'h0000_0000);
        wr(timer16_pkg::OFS_MODE, 32'h0000_0000);
        rd(timer16_pkg::OFS_MODE, va);
        check("overflow cleared", va, 32'h0000_0000);
        wr(timer16_pkg::OFS_PRESC, 32'h0000_0001);
        wr(timer16_pkg::OFS_MODE, 32'h0000_0004);
        rd(timer16_pkg::OFS_COUNT, va);
        repeat (80) @(posedge sys_clk);
        rd(timer16_pkg::OFS_COUNT, vb);
        check_true("slow count rate", (vb - va) >= 10 && (vb - va) <= 11);
        $display("test reset done");

        // Free-run counting and two compare matches
        do_reset();
        wr(timer16_pkg::OFS_CC_A, 32'h0000_0040);
        wr(timer16_pkg::OFS_CC_B, 32'h0000_0080);
        wr(timer16_pkg::OFS_OUTCTL, 32'h0000_0001);
        wr(timer16_pkg::OFS_MODE, 32'h0000_0004);
        rd(timer16_pkg::OFS_COUNT, va);
        repeat (40) @(posedge sys_clk);
        rd(timer16_pkg::OFS_COUNT, vb);
        check_true("count rate", (vb - va) >= 20 && (vb - va) <= 23);
        wait_int(1'b0);
        check("pin after A", {31'h0, timer_output_pin}, 32'h0000_0001);
        rd(timer16_pkg::OFS_COUNT, va);
        check_true("count kept", va > 32'h0000_0040);
        wait_int(1'b1);
        check("pin after B", {31'h0, timer_output_pin}, 32'h0000_0000);
        $display("test free compare done");

        // Free-run capture into B, spike rejection, toggle-on-trigger choice
        do_reset();
        wr(timer16_pkg::OFS_CAPCOMP, 32'h0000_0004);
        wr(timer16_pkg::OFS_PRESC, 32'h0000_0010);
        wr(timer16_pkg::OFS_OUTCTL, 32'h0000_0001);
        wr(timer16_pkg::OFS_MODE, 32'h0000_0004);
        repeat (60) @(posedge sys_clk);
        sb = cnt_b;
        i_src.glitch();
        check("spike ignored", cnt_b, sb);
        i_src.set_pin(0, 1'b1);
        check("capture int B", cnt_b, sb + 1);
        rd(timer16_pkg::OFS_CC_B, vb);
        rd(timer16_pkg::OFS_COUNT, va);
        check_true("B captured", vb > 32'h0000_0010 && (va - vb) <= 8);
        wr(timer16_pkg::OFS_CAPCOMP, 32'h0000_0007);
        i_src.set_pin(0, 1'b0);
        i_src.set_pin(0, 1'b1);
        check("no toggle", {31'h0, timer_output_pin}, 32'h0000_0000);
        wr(timer16_pkg::OFS_MODE, 32'h0000_0006);
        i_src.set_pin(0, 1'b0);
        i_src.set_pin(0, 1'b1);
        check("trigger toggle", {31'h0, timer_output_pin}, 32'h0000_0001);
        $display("test free capture done");

        // Clear-and-start with compare B and toggling
        do_reset();
        wr(timer16_pkg::OFS_CC_A, 32'h0000_FFFF);
        wr(timer16_pkg::OFS_CC_B, 32'h0000_0010);
        wr(timer16_pkg::OFS_OUTCTL, 32'h0000_0001);
        wr(timer16_pkg::OFS_PRESC, 32'h0000_0010);
        wr(timer16_pkg::OFS_MODE, 32'h0000_000A);
        wait_int(1'b1);
        check("pin B match", {31'h0, timer_output_pin}, 32'h0000_0001);
        i_src.set_pin(0, 1'b1);
        check("pin on clear", {31'h0, timer_output_pin}, 32'h0000_0000);
        rd(timer16_pkg::OFS_COUNT, va);
        check_true("count cleared", va < 32'h0000_0008);
        wait_int(1'b1);
        check("pin B again", {31'h0, timer_output_pin}, 32'h0000_0001);
        $display("test clear start done");

        // Reverse phase capture, secondary edges, then A from secondary
        do_reset();
        wr(timer16_pkg::OFS_CAPCOMP, 32'h0000_0007);
        wr(timer16_pkg::OFS_PRESC, 32'h0000_00D0);
        wr(timer16_pkg::OFS_MODE, 32'h0000_0008);
        repeat (40) @(posedge sys_clk);
        sb = cnt_b;
        i_src.set_pin(0, 1'b1);
        check("clear capture int", cnt_b, sb + 1);
        rd(timer16_pkg::OFS_CC_B, vb);
        check_true("B captured", vb > 32'h0000_0008);
        repeat (30) @(posedge sys_clk);
        sa = cnt_a;
        i_src.set_pin(0, 1'b0);
        check("reverse no int", cnt_a, sa);
        rd(timer16_pkg::OFS_CC_A, va);
        check_true("reverse capture", va > 32'h0000_0008 && va < 32'h0000_0030);
        i_src.set_pin(1, 1'b1);
        i_src.set_pin(1, 1'b0);
        check("secondary ints", cnt_a, sa + 2);
        rd(timer16_pkg::OFS_CC_A, vb);
        check("A kept", vb, va);
        wr(timer16_pkg::OFS_CAPCOMP, 32'h0000_0005);
        wr(timer16_pkg::OFS_OUTCTL, 32'h0000_0001);
        wr(timer16_pkg::OFS_MODE, 32'h0000_000A);
        sa = cnt_a;
        i_src.set_pin(1, 1'b1);
        check("secondary int", cnt_a, sa + 1);
        rd(timer16_pkg::OFS_CC_A, vb);
        check_true("A from secondary", vb !== va);
        i_src.set_pin(0, 1'b1);
        check("pin held low", {31'h0, timer_output_pin}, 32'h0000_0000);
        $display("test reverse phase done");
        complete_run();
    end
endmodule : test_timer16_capture_freerun
